// *** logic/psram_sync_burst_port.sv ***
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "psram_burst_params.svh"

module psram_sync_burst_port #(
  parameter int AW     = 22,
  parameter int DW     = 16,
  parameter int MEM_AW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [3:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // memory pins
  input  wire logic          host_clk_i,
  input  wire logic          cs_n_i,
  input  wire logic          addr_valid_n_i,
  input  wire logic          we_n_i,
  input  wire logic          mode_set_pin_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] dq_i,
  output logic      [DW-1:0] dq_o,
  output logic               dq_oe_o,
  output logic               wait_o,
  output logic               partial_refresh_o
);
  import psram_burst_pkg::*;

  localparam int SW       = 5 + AW + DW;
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam logic [4:0] REFR_CYC = 5'(`REFR_ENTRY_CYC);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [3:0] decode_latency(input logic [2:0] code);
    case (code)
      `LAT_CODE_3: decode_latency = 4'h3;
      `LAT_CODE_4: decode_latency = 4'h4;
      `LAT_CODE_6: decode_latency = 4'h6;
      default:     decode_latency = 4'h5;
    endcase
  endfunction

  function automatic logic [8:0] decode_len(input logic [2:0] code);
    case (code)
      `LEN_CODE_4:   decode_len = 9'h004;
      `LEN_CODE_8:   decode_len = 9'h008;
      `LEN_CODE_256: decode_len = 9'h100;
      default:      decode_len = 9'h010;
    endcase
  endfunction

  // block kept alive during partial refresh
  function automatic logic retained(input logic [1:0] blk, input logic top, input logic [1:0] size);
    logic [1:0] b;
    b = top ? ~blk : blk;
    case (size)
      `SIZE_3Q:   retained = (b != 2'h3);
      `SIZE_HALF: retained = (b <= 2'h1);
      `SIZE_1Q:   retained = (b == 2'h0);
      default:    retained = 1'b1;
    endcase
  endfunction

  function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] start, input logic [7:0] idx,
                                               input logic [8:0] len, input logic ileave);
    logic [7:0] mask;
    logic [7:0] low;
    mask = 8'(len - 9'h001);
    low  = ileave ? (start[7:0] ^ idx) : 8'(start[7:0] + idx);
    burst_addr = {start[AW-1:8], (start[7:0] & ~mask) | (low & mask)};
  endfunction

  function automatic logic [MEM_AW-1:0] mem_index(input logic [AW-1:0] a);
    mem_index = {a[AW-1:AW-2], a[MEM_AW-3:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SW-1:0] pin_s1_reg;
  logic [SW-1:0] pin_s2_reg;
  logic          hclk_prev_reg;
  logic          adv_n_prev_reg;
  logic [AW-1:0] addr_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_reg     <= '1;
      pin_s2_reg     <= '1;
      hclk_prev_reg  <= 1'b1;
      adv_n_prev_reg <= 1'b1;
      addr_prev_reg  <= '0;
    end else begin
      pin_s1_reg     <= {host_clk_i, cs_n_i, addr_valid_n_i, we_n_i, mode_set_pin_n_i, addr_i, dq_i};
      pin_s2_reg     <= pin_s1_reg;
      hclk_prev_reg  <= pin_s2_reg[SW-1];
      adv_n_prev_reg <= pin_s2_reg[SW-3];
      addr_prev_reg  <= pin_s2_reg[DW +: AW];
    end
  end

  logic          hclk_s;
  logic          cs_n_s;
  logic          adv_n_s;
  logic          we_n_s;
  logic          mset_n_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] dq_s;
  logic          hclk_rise;
  logic          adv_rise;

  assign {hclk_s, cs_n_s, adv_n_s, we_n_s, mset_n_s, addr_s, dq_s} = pin_s2_reg;
  assign hclk_rise = hclk_s & ~hclk_prev_reg;
  assign adv_rise  = adv_n_s & ~adv_n_prev_reg;

  ////////////////////////////////////////////////////////////////////////
  // register bus

  logic [15:0] cfg_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status;
  logic        bus_req;

  assign bus_req = cyc_i & stb_i & ~ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg <= `CFG_RESET;
    end else if (bus_req && we_i && adr_i == `REG_CFG_OFS) begin
      if (sel_i[0])
        cfg_reg[7:0] <= dat_i[7:0];
      if (sel_i[1])
        cfg_reg[15:8] <= dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= bus_req;
      if (bus_req && !we_i) begin
        case (adr_i)
          `REG_CFG_OFS:    rdata_reg <= {16'h0000, cfg_reg};
          `REG_STATUS_OFS: rdata_reg <= status;
          default:         rdata_reg <= '0;
        endcase
      end
    end
  end

  assign dat_o = rdata_reg;
  assign ack_o = ack_reg;

  // configuration decode, reserved codes fall back to defaults
  logic       cfg_wp;
  logic [3:0] cfg_lat;
  logic [8:0] cfg_len;
  logic       cfg_ileave;
  logic       cfg_refr_en;

  assign cfg_wp     = cfg_reg[`CFG_WP_BIT];
  assign cfg_lat    = decode_latency(cfg_reg[`CFG_LAT_HI:`CFG_LAT_LO]);
  assign cfg_len    = decode_len(cfg_reg[`CFG_LEN_HI:`CFG_LEN_LO]);
  assign cfg_ileave = cfg_reg[`CFG_ORDER_BIT] & (cfg_len != 9'h100);
  assign cfg_refr_en = (cfg_reg[`CFG_REFR_HI:`CFG_REFR_LO] == `REFR_CODE_ENABLE);

  ////////////////////////////////////////////////////////////////////////
  // burst engine

  burst_state_t  state_reg;
  logic [9:0]    rise_cnt_reg;
  logic [3:0]    first_reg;
  logic [8:0]    len_reg;
  logic          ileave_reg;
  logic [AW-1:0] start_reg;
  logic [AW-1:0] held_addr_reg;
  logic          held_vld_reg;
  logic          refr_active_reg;
  logic          command;
  logic [9:0]    rise_next;
  logic [9:0]    word_idx;
  logic          data_rise;
  logic [AW-1:0] cur_addr;

  // refresh mode blocks new commands; a busy burst, read or write, also ignores the strobe
  assign command   = (state_reg == ST_IDLE) && hclk_rise && !cs_n_s && !adv_n_s && !refr_active_reg;
  assign rise_next = rise_cnt_reg + 10'h001;
  assign word_idx  = rise_next - {6'h00, first_reg};
  assign data_rise = (state_reg != ST_IDLE) && hclk_rise && (rise_next >= {6'h00, first_reg});
  assign cur_addr  = burst_addr(start_reg, word_idx[7:0], len_reg, ileave_reg);

  // whichever of clock rise or strobe release comes first fixes the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_addr_reg <= '0;
      held_vld_reg  <= 1'b0;
    end else if (command || cs_n_s) begin
      held_vld_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && adv_rise && !held_vld_reg) begin
      held_addr_reg <= addr_prev_reg;
      held_vld_reg  <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      rise_cnt_reg <= '0;
      first_reg    <= 4'h0;
      len_reg      <= 9'h010;
      ileave_reg   <= 1'b0;
      start_reg    <= '0;
    end else if (command) begin
      state_reg    <= we_n_s ? ST_READ : ST_WRITE;
      rise_cnt_reg <= '0;
      first_reg    <= we_n_s ? 4'(cfg_lat + 4'h1) : 4'(cfg_lat - 4'h1);
      len_reg      <= cfg_len;
      ileave_reg   <= cfg_ileave;
      start_reg    <= held_vld_reg ? held_addr_reg : addr_s;
    end else if (state_reg != ST_IDLE && cs_n_s) begin
      state_reg <= ST_IDLE;
    end else if (hclk_rise && state_reg != ST_IDLE) begin
      rise_cnt_reg <= rise_next; // later rises only count on
      if (data_rise && word_idx == {1'b0, len_reg})
        state_reg <= ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage, per-word validity lost when a block stops refreshing

  logic [DW-1:0] mem [MEM_WORDS];
  logic          vld_reg [MEM_WORDS];
  logic          wr_take;
  logic          enter_refr;

  assign wr_take = state_reg == ST_WRITE && !cs_n_s && data_rise && word_idx < {1'b0, len_reg};

  always_ff @(posedge clk_i) begin
    if (wr_take)
      mem[mem_index(cur_addr)] <= dq_s;
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < MEM_WORDS; i++) begin
      if (rst_i)
        vld_reg[i] <= 1'b0;
      else if (enter_refr && !retained(2'(i >> (MEM_AW - 2)), cfg_reg[`CFG_REFR_TOP_BIT],
                                       cfg_reg[`CFG_REFR_SIZE_HI:`CFG_REFR_SIZE_LO]))
        vld_reg[i] <= 1'b0;
      else if (wr_take && mem_index(cur_addr) == MEM_AW'(i))
        vld_reg[i] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin outputs

  logic [DW-1:0] dq_reg;
  logic          dq_oe_reg;
  logic          waitv_reg;
  logic          busy_wait_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_reg    <= '0;
      dq_oe_reg <= 1'b0;
    end else if (state_reg != ST_READ || cs_n_s) begin
      dq_oe_reg <= 1'b0;
    end else if (data_rise) begin
      // one word per rise from the latency point, no stall on the first
      dq_oe_reg <= word_idx < {1'b0, len_reg};
      dq_reg    <= vld_reg[mem_index(cur_addr)] ? mem[mem_index(cur_addr)] : '0;
    end
  end

  // data-valid state is reached one host clock ahead of the word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waitv_reg     <= 1'b0;
      busy_wait_reg <= 1'b0;
    end else if (command) begin
      busy_wait_reg <= 1'b1;
      waitv_reg     <= (4'h1 >= first_reg) && 1'b0;
    end else if (state_reg == ST_IDLE || cs_n_s) begin
      busy_wait_reg <= 1'b0;
      waitv_reg     <= 1'b0;
    end else if (hclk_rise && rise_next + 10'h001 >= {6'h00, first_reg}) begin
      waitv_reg <= 1'b1;
    end
  end

  // asserted means not ready; low-enable inverts the pin
  assign wait_o  = cfg_wp ? (busy_wait_reg & ~waitv_reg) : ~(busy_wait_reg & ~waitv_reg);
  assign dq_o    = dq_reg;
  assign dq_oe_o = dq_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // partial refresh entry and exit

  logic [4:0] mset_cnt_reg;
  logic       cmd_in_low_reg;

  // a command soon after the pin falls means programming, not refresh
  assign enter_refr = !refr_active_reg && cfg_refr_en && !mset_n_s && !cmd_in_low_reg
                      && mset_cnt_reg == REFR_CYC;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mset_cnt_reg    <= '0;
      cmd_in_low_reg  <= 1'b0;
      refr_active_reg <= 1'b0;
    end else if (mset_n_s) begin
      mset_cnt_reg    <= '0;
      cmd_in_low_reg  <= 1'b0;
      refr_active_reg <= 1'b0;
    end else begin
      if (mset_cnt_reg != REFR_CYC)
        mset_cnt_reg <= mset_cnt_reg + 5'h01;
      if (command && !refr_active_reg)
        cmd_in_low_reg <= 1'b1;
      if (enter_refr)
        refr_active_reg <= 1'b1;
    end
  end

  assign partial_refresh_o = refr_active_reg;

  always_comb begin
    status                       = '0;
    status[`STAT_BUSY_BIT]       = state_reg != ST_IDLE;
    status[`STAT_REFR_BIT]       = refr_active_reg;
    status[`STAT_WRITE_BIT]      = state_reg == ST_WRITE;
    status[`STAT_WAITV_BIT]      = waitv_reg;
    status[`STAT_ADDR_LO +: AW]  = start_reg;
  end

endmodule // psram_sync_burst_port

// *** logic/psram_burst_params.svh ***
`ifndef PSRAM_BURST_PARAMS_SVH
`define PSRAM_BURST_PARAMS_SVH

// register byte offsets
`define REG_CFG_OFS       4'h0
`define REG_STATUS_OFS    4'h4

// configuration field positions
`define CFG_WP_BIT        13
`define CFG_LAT_HI        11
`define CFG_LAT_LO        9
`define CFG_ORDER_BIT     8
`define CFG_LEN_HI        7
`define CFG_LEN_LO        5
`define CFG_REFR_HI       4
`define CFG_REFR_LO       3
`define CFG_REFR_TOP_BIT  2
`define CFG_REFR_SIZE_HI  1
`define CFG_REFR_SIZE_LO  0
`define CFG_RESET         16'h0498

// field codes
`define LAT_CODE_3        3'h0
`define LAT_CODE_4        3'h1
`define LAT_CODE_5        3'h2
`define LAT_CODE_6        3'h3
`define LEN_CODE_4        3'h2
`define LEN_CODE_8        3'h3
`define LEN_CODE_16       3'h4
`define LEN_CODE_256      3'h7
`define REFR_CODE_ENABLE  2'h2
`define SIZE_FULL         2'h0
`define SIZE_3Q           2'h1
`define SIZE_HALF         2'h2
`define SIZE_1Q           2'h3

// status field positions
`define STAT_BUSY_BIT     0
`define STAT_REFR_BIT     1
`define STAT_WRITE_BIT    2
`define STAT_WAITV_BIT    3
`define STAT_ADDR_LO      8

// timing
`define CLK_PERIOD_NS     25
`define REFR_ENTRY_NS     500
`define REFR_ENTRY_CYC    (`REFR_ENTRY_NS / `CLK_PERIOD_NS)

`endif

// *** logic/psram_burst_pkg.sv ***
package psram_burst_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } burst_state_t;
endpackage

// *** test/psram_port_chk.sv ***
`timescale 1ns/1ps
module psram_port_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        cs_n_i,
  input wire logic        mode_set_pin_n_i,
  input wire logic        dq_oe_o,
  input wire logic        wait_o,
  input wire logic        partial_refresh_o
);
  // polarity copy lets the pin be read as ready whatever its sense
  logic       wp_reg;
  logic [5:0] low_reg;
  logic       rdy;
  assign rdy = wait_o ^ wp_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) wp_reg <= 1'b0;
    else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 4'h0 && sel_i[1]) wp_reg <= dat_i[13];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || mode_set_pin_n_i) low_reg <= 6'h00;
    else if (low_reg != 6'h3F) low_reg <= low_reg + 6'h01;
  end
  //////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_cs_stop: assert property (cs_n_i [*5] |-> !dq_oe_o) else $error("drives deselected");
  a_idle_wait: assert property (cs_n_i [*5] |-> rdy) else $error("wait not idle");
  a_data_ready: assert property (dq_oe_o |-> rdy) else $error("wait in data");
  a_wait_lead: assert property ($rose(dq_oe_o) |-> $past(rdy, 7) && !$past(rdy, 9))
    else $error("wait lead wrong");
  a_oe_stand: assert property ($rose(dq_oe_o) |-> dq_oe_o [*8]) else $error("word too short");
  a_refr_entry: assert property ($rose(partial_refresh_o) |-> $past(low_reg, 3) >= 6'h12)
    else $error("refresh without pin");
  a_refr_exit: assert property (mode_set_pin_n_i [*5] |-> !partial_refresh_o) else $error("refresh kept");
  c_read: cover property ($rose(dq_oe_o));
  c_stop: cover property (dq_oe_o ##1 cs_n_i);
  c_refr: cover property ($rose(partial_refresh_o));
endmodule // psram_port_chk
bind psram_sync_burst_port psram_port_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .ack_o, .cs_n_i, .mode_set_pin_n_i, .dq_oe_o, .wait_o, .partial_refresh_o);

// *** test/psram_host_model.sv ***
`timescale 1ns/1ps
module psram_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] dq_i,
  output logic             host_clk_o,
  output logic             cs_n_o,
  output logic             addr_valid_n_o,
  output logic             we_n_o,
  output logic             mode_set_pin_n_o,
  output logic [21:0]      addr_o,
  output logic [15:0]      dq_o
);
  logic [15:0] wr_q[$];
  logic [15:0] rd_q[$];
  initial begin
    host_clk_o = 1'b0;
    cs_n_o = 1'b1;
    addr_valid_n_o = 1'b1;
    we_n_o = 1'b1;
    mode_set_pin_n_o = 1'b1;
    addr_o = 22'h0;
    dq_o = 16'h0;
  end
  //////////////////////////////////////////////////////////////////
  // clock runs only inside a frame; frames never overlap
  // only synchronous bursts are ever issued, no async writes around them
  task automatic burst(input logic wr, input int lat, input logic [21:0] a, input int n);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    addr_valid_n_o <= 1'b0;
    we_n_o <= !wr;
    addr_o <= a;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < (wr ? lat + n : lat + n + 2); i++) begin
      host_clk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      host_clk_o <= 1'b0;
      addr_valid_n_o <= 1'b1;
      we_n_o <= 1'b1;
      // released lines toggle so stale values never pass as data
      addr_o <= ~addr_o;
      if (wr && i + 2 >= lat && i + 2 < lat + n) dq_o <= wr_q.pop_front();
      else dq_o <= ~dq_o;
      repeat (2) @(posedge clk_i);
      if (!wr && i > lat && i <= lat + n) rd_q.push_back(dq_i);
      repeat (2) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pin(input logic v);
    @(posedge clk_i);
    mode_set_pin_n_o <= v;
  endtask
endmodule // psram_host_model

// *** test/psram_sync_burst_port_bench.sv ***
`timescale 1ns/1ps
module psram_sync_burst_port_bench;
  logic        clk_i;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack, hclk, cs_n, adv_n, we_n, ms_n, oe, wt, refr;
  logic [21:0] haddr;
  logic [15:0] hdq, dq;
  logic [15:0] mem[int];
  int          error_cnt = 0;
  int          samples_checked = 0;
  psram_sync_burst_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .host_clk_i(hclk), .cs_n_i(cs_n),
    .addr_valid_n_i(adv_n), .we_n_i(we_n), .mode_set_pin_n_i(ms_n), .addr_i(haddr), .dq_i(hdq), .dq_o(dq),
    .dq_oe_o(oe), .wait_o(wt), .partial_refresh_o(refr));
  psram_host_model host (.clk_i(clk_i), .dq_i(dq), .host_clk_o(hclk), .cs_n_o(cs_n), .addr_valid_n_o(adv_n),
    .we_n_o(we_n), .mode_set_pin_n_o(ms_n), .addr_o(haddr), .dq_o(hdq));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'h3};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    chk(t < 20, 1'b1, "bus ack");
  endtask
  function automatic int ix(logic [21:0] a);
    return int'({a[21:20], a[5:0]});
  endfunction
  function automatic logic [21:0] at(logic [21:0] a, int bl, logic il, int k);
    int s;
    s = int'(a) % bl;
    return 22'(int'(a) - s + ((il && bl < 256) ? (s ^ k) : ((s + k) % bl)));
  endfunction
  task automatic rw(input logic wr, input int lat, input logic [21:0] a, input int bl, input int n, input logic il);
    logic [15:0] d;
    for (int k = 0; k < n && wr; k++) begin
      d = 16'($urandom);
      host.wr_q.push_back(d);
      mem[ix(at(a, bl, il, k))] = d;
    end
    host.burst(wr, lat, a, n);
    for (int k = 0; k < n && !wr; k++) begin
      d = mem.exists(ix(at(a, bl, il, k))) ? mem[ix(at(a, bl, il, k))] : 16'h0;
      chk(host.rd_q.pop_front(), d, "read word");
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
  initial begin
    logic [31:0] q;
    logic [21:0] a;
    logic        wp, il;
    int          lt[5] = '{3, 4, 5, 6, 5};
    int          bs[5] = '{4, 8, 16, 256, 16};
    logic [2:0]  lc[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic [2:0]  bc[5] = '{3'h2, 3'h3, 3'h4, 3'h7, 3'h0};
    int          n;
    q = $urandom(32'h2194);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0498, "cfg reset");
    wb(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    $display("regs done");
    foreach (lt[i]) foreach (bs[j]) begin // every latency suits the slow link clock
      wp = 1'($urandom);
      il = 1'($urandom);
      wb(1'b1, 4'h0, {18'h0, wp, 1'b0, lc[i], il, bc[j], 5'h18}, q);
      chk(wt, !wp, "idle wait");
      a = 22'($urandom);
      // full page is cut short by chip select so the frame fits the cycle-time limit
      n = (bs[j] == 256) ? 3 : bs[j];
      rw(1'b1, lt[i], a, bs[j], n, il);
      rw(1'b0, lt[i], a ^ 22'($urandom % bs[j]), bs[j], n, il);
    end
    $display("orders done");
    wb(1'b1, 4'h0, 32'h0098, q);
    a = 22'($urandom);
    rw(1'b1, 3, a, 16, 16, 1'b0);
    rw(1'b0, 3, a, 16, 1, 1'b0);
    rw(1'b0, 3, a, 16, 2, 1'b0);
    rw(1'b0, 3, a, 16, 16, 1'b0);
    $display("stop done");
    for (int k = 0; k < 7; k++) begin
      wb(1'b1, 4'h0, {21'h2, (k < 6) ? 2'h2 : 2'h3, 1'(k % 2), 2'(1 + k / 2)}, q);
      for (int b = 0; b < 4; b++) rw(1'b1, 3, 22'(b) << 20, 4, 4, 1'b0);
      host.pin(1'b0);
      repeat (40) @(posedge clk_i);
      chk(refr, k < 6, "refresh entry");
      host.pin(1'b1);
      repeat (8) @(posedge clk_i);
      chk(refr, 1'b0, "refresh exit");
      for (int b = 0; b < 4; b++) begin
        if (k < 6 && ((k % 2) ? b < 1 + k / 2 : b >= 3 - k / 2))
          for (int w = 0; w < 4; w++) mem[ix((22'(b) << 20) | 22'(w))] = 16'h0;
        rw(1'b0, 3, 22'(b) << 20, 4, 4, 1'b0);
      end
    end
    $display("refresh done");
    summarize();
  end
endmodule // psram_sync_burst_port_bench
